// ---- afe_port_pkg.sv ----
// Constants shared by the modem front-end serial port
package afe_port_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONTROL   = 10'h200;
  localparam logic [9:0] IDX_STATUS    = 10'h202;
  localparam logic [9:0] IDX_RX_WORD   = 10'h204;
  localparam logic [9:0] IDX_TX_WORD   = 10'h206;
  localparam logic [9:0] IDX_TX_BUF    = 10'h100;
  localparam logic [9:0] IDX_RX_BUF    = 10'h000;
  localparam logic [9:0] IDX_BUF_SPAN  = 10'h05F;
  // Buffer geometry
  localparam int         BUF_WORDS     = 48;
  localparam logic [6:0] BUF_ONE_BASE  = 7'h30;
  localparam logic [5:0] BUF_LAST      = 6'h2F;
  localparam logic [4:0] WORD_LAST_BIT = 5'h0F;
  // Control register fields
  localparam int CTL_RELAY_LEVEL = 12;
  localparam int CTL_POWERDOWN   = 11;
  localparam int CTL_CHIP_RESET  = 10;
  localparam int CTL_RELAY_SRC   = 9;
  localparam int CTL_RX_SRC      = 8;
  localparam int CTL_RING_MASK   = 7;
  localparam int CTL_TXERR_IE    = 6;
  localparam int CTL_RXERR_IE    = 5;
  localparam int CTL_TXEMPTY_IE  = 4;
  localparam int CTL_RXFULL_IE   = 3;
  localparam int CTL_BUF_DISABLE = 2;
  localparam int CTL_TX_ENABLE   = 1;
  localparam int CTL_RX_ENABLE   = 0;
  // Status register fields
  localparam int STS_TX_ACCESS = 15;
  localparam int STS_RX_ACCESS = 14;
  localparam int STS_TX_ERROR  = 3;
  localparam int STS_RX_ERROR  = 2;
  localparam int STS_TX_EMPTY  = 1;
  localparam int STS_RX_FULL   = 0;
  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [1:0]  TX_EMPTY_RESET = 2'h3;
endpackage

// ---- modem_afe_serial_port.sv ----
// Modem front-end serial port: registers, ping-pong buffers, shifters
module modem_afe_serial_port (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Avalon-MM slave, word addressed
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Front-end link pins
  input  wire logic        shift_clk,
  input  wire logic        frame_sync,
  input  wire logic        rx_data,
  input  wire logic        ring_in,
  output logic             tx_data,
  output logic             relay_output,
  output logic             ext_chip_reset_n,
  output logic             ext_chip_powerdown_n,
  // Interrupt request levels
  output logic             ring_irq,
  output logic             tx_error_irq,
  output logic             rx_error_irq,
  output logic             tx_empty_irq,
  output logic             rx_full_irq
);
  logic [15:0] ctl_reg;
  logic [15:0] tx_word_reg;
  logic [15:0] rx_word_reg;
  logic        tab_reg, rab_reg;
  logic        tx_err_reg, rx_err_reg, tde_reg, rdf_reg;
  logic [3:0]  arm_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [15:0] tx_mem [0:2*afe_port_pkg::BUF_WORDS-1];
  logic [15:0] rx_mem [0:2*afe_port_pkg::BUF_WORDS-1];
  logic [1:0]  tx_empty_reg, rx_full_reg;
  logic        tx_active_reg, rx_fill_reg, tx_last_reg, tx_last_buf_reg;
  logic [5:0]  tx_idx_reg, rx_idx_reg;
  logic        tx_word_full_reg, te_prev_reg, re_prev_reg;
  logic [3:0]  pin_meta_reg, pin_sync_reg;
  logic [1:0]  edge_prev_reg;
  logic [15:0] tx_shifter_reg, rx_shifter_reg;
  logic [4:0]  bit_cnt_reg;
  logic        frame_active_reg;
  // Decoded link state
  logic sclk_s, fs_s, rxd_s, ring_s, fs_rise, sclk_fall, rx_bit, word_done;
  logic buffer_disable, te, re, te_fall, re_fall, tx_load, tx_sel;
  logic [15:0] tx_next_word;
  assign sclk_s = pin_sync_reg[0];
  assign fs_s   = pin_sync_reg[1];
  assign rxd_s  = pin_sync_reg[2];
  assign ring_s = pin_sync_reg[3];
  assign fs_rise   = fs_s & ~edge_prev_reg[1];
  assign sclk_fall = ~sclk_s & edge_prev_reg[0];
  assign buffer_disable = ctl_reg[afe_port_pkg::CTL_BUF_DISABLE];
  assign te   = ctl_reg[afe_port_pkg::CTL_TX_ENABLE];
  assign re   = ctl_reg[afe_port_pkg::CTL_RX_ENABLE];
  assign te_fall = te_prev_reg & ~te;
  assign re_fall = re_prev_reg & ~re;
  assign rx_bit = ctl_reg[afe_port_pkg::CTL_RX_SRC] ? ring_s : rxd_s;
  assign word_done = frame_active_reg & sclk_fall & (bit_cnt_reg == afe_port_pkg::WORD_LAST_BIT);
  assign tx_load = fs_rise & te;
  // Drain whichever buffer is full when the current one ran dry
  assign tx_sel = tx_empty_reg[tx_active_reg] ? ~tx_active_reg : tx_active_reg;
  // Buffer word index: buffer one sits above buffer zero
  function automatic logic [6:0] mem_index(input logic sel, input logic [5:0] k);
    mem_index = sel ? (afe_port_pkg::BUF_ONE_BASE + {1'b0, k}) : {1'b0, k};
  endfunction
  // Bus decode
  logic        req, wr_go, rd_go, hit_tx_buf, hit_rx_buf;
  logic [9:0]  tx_off, rx_off;
  logic [5:0]  tx_k, rx_k;
  assign req    = avs_read | avs_write;
  assign wr_go  = avs_write & ~wait_reg;
  assign rd_go  = avs_read & ~wait_reg;
  assign tx_off = avs_address - afe_port_pkg::IDX_TX_BUF;
  assign rx_off = avs_address - afe_port_pkg::IDX_RX_BUF;
  assign tx_k   = tx_off[6:1];
  assign rx_k   = rx_off[6:1];
  assign hit_tx_buf = (avs_address >= afe_port_pkg::IDX_TX_BUF) && !avs_address[0] &&
                      (tx_off <= afe_port_pkg::IDX_BUF_SPAN);
  assign hit_rx_buf = (rx_off <= afe_port_pkg::IDX_BUF_SPAN) && !avs_address[0];
  // Byte lanes merged onto the old value
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
  endfunction
  logic [15:0] status_word, sw_status;
  assign status_word = {tab_reg, rab_reg, 10'h000, tx_err_reg, rx_err_reg, tde_reg, rdf_reg};
  assign sw_status = merge(status_word, avs_writedata, avs_byteenable);
  logic st_wr;
  assign st_wr = wr_go && (avs_address == afe_port_pkg::IDX_STATUS);
  // Write 0 to a flag previously read as 1
  logic [3:0] clr_op;
  assign clr_op = st_wr ? (arm_reg & ~sw_status[3:0]) : 4'h0;
  // One wait cycle, then answer; wait rises again after the taken edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(req & wait_reg);
    end
  end
  // Read mux captured during the wait cycle so data stand at the taken edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req & wait_reg) begin
      rdata_reg <= 32'h0000_0000;
      if (avs_address == afe_port_pkg::IDX_CONTROL) begin
        rdata_reg[15:0] <= ctl_reg;
      end else if (avs_address == afe_port_pkg::IDX_STATUS) begin
        rdata_reg[15:0] <= status_word;
      end else if (avs_address == afe_port_pkg::IDX_TX_WORD) begin
        rdata_reg[15:0] <= tx_word_reg;
      end else if (avs_address == afe_port_pkg::IDX_RX_WORD) begin
        rdata_reg[15:0] <= rx_word_reg;
      end else if (hit_tx_buf) begin
        rdata_reg[15:0] <= tx_mem[mem_index(tab_reg, tx_k)];
      end else if (hit_rx_buf) begin
        rdata_reg[15:0] <= rx_mem[mem_index(rab_reg, rx_k)];
      end
    end
  end
  // Control and transmit word registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctl_reg     <= afe_port_pkg::CONTROL_RESET;
      tx_word_reg <= afe_port_pkg::WORD_RESET;
    end else if (wr_go) begin
      if (avs_address == afe_port_pkg::IDX_CONTROL) begin
        ctl_reg <= merge(ctl_reg, avs_writedata, avs_byteenable);
      end
      if (avs_address == afe_port_pkg::IDX_TX_WORD) begin
        tx_word_reg <= merge(tx_word_reg, avs_writedata, avs_byteenable);
      end
    end
  end
  // Software side of transmit buffer; no reset so contents survive standby
  always_ff @(posedge sys_clk) begin
    if (wr_go && hit_tx_buf) begin
      tx_mem[mem_index(tab_reg, tx_k)] <= merge(tx_mem[mem_index(tab_reg, tx_k)],
                                                avs_writedata, avs_byteenable);
    end
  end
  // Status read arms the flags that were seen set
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      arm_reg <= 4'h0;
    end else if (rd_go && avs_address == afe_port_pkg::IDX_STATUS) begin
      arm_reg <= status_word[3:0];
    end else if (st_wr) begin
      arm_reg <= 4'h0;
    end
  end
  // Two-flop synchronisers for link pins; edge history reads only stage two
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_meta_reg  <= 4'h0;
      pin_sync_reg  <= 4'h0;
      edge_prev_reg <= 2'h0;
      te_prev_reg   <= 1'b0;
      re_prev_reg   <= 1'b0;
    end else begin
      pin_meta_reg  <= {ring_in, rx_data, frame_sync, shift_clk};
      pin_sync_reg  <= pin_meta_reg;
      edge_prev_reg <= pin_sync_reg[1:0];
      te_prev_reg   <= te;
      re_prev_reg   <= re;
    end
  end
  // Word to send at frame start
  always_comb begin
    if (buffer_disable) begin
      tx_next_word = tx_word_reg;
    end else if (!tx_empty_reg[tx_sel]) begin
      tx_next_word = tx_mem[mem_index(tx_sel, tx_idx_reg)];
    end else begin
      tx_next_word = 16'h0000;
    end
  end
  // Frame timing: frame sync starts a word, shift clock fall moves one bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frame_active_reg <= 1'b0;
      bit_cnt_reg      <= 5'h00;
      tx_data          <= 1'b0;
    end else if (fs_rise) begin
      frame_active_reg <= 1'b1;
      bit_cnt_reg      <= 5'h00;
      tx_data          <= te ? tx_next_word[15] : 1'b0;
    end else if (frame_active_reg && sclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      tx_data     <= te ? tx_shifter_reg[14] : 1'b0;
      if (bit_cnt_reg == afe_port_pkg::WORD_LAST_BIT) begin
        frame_active_reg <= 1'b0;
      end
    end else if (!te) begin
      tx_data <= 1'b0;
    end
  end
  // Shifters carry no reset; their contents are don't-care until loaded
  always_ff @(posedge sys_clk) begin
    if (tx_load) begin
      tx_shifter_reg <= tx_next_word;
    end else if (frame_active_reg && sclk_fall) begin
      tx_shifter_reg <= {tx_shifter_reg[14:0], 1'b0};
    end
    if (frame_active_reg && sclk_fall) begin
      rx_shifter_reg <= {rx_shifter_reg[14:0], rx_bit};
    end
  end
  // Transmit buffer walk and empty tracking
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_empty_reg     <= afe_port_pkg::TX_EMPTY_RESET;
      tx_active_reg    <= 1'b0;
      tx_idx_reg       <= 6'h00;
      tx_last_reg      <= 1'b0;
      tx_last_buf_reg  <= 1'b0;
      tx_word_full_reg <= 1'b0;
    end else begin
      if (wr_go && avs_address == afe_port_pkg::IDX_TX_WORD) begin
        tx_word_full_reg <= 1'b1;
      end else if (tx_load && buffer_disable) begin
        tx_word_full_reg <= 1'b0;
      end
      if (te_fall) begin
        tx_empty_reg <= 2'h3;
        tx_idx_reg   <= 6'h00;
        tx_last_reg  <= 1'b0;
      end else begin
        if (clr_op[afe_port_pkg::STS_TX_EMPTY]) begin
          tx_empty_reg[tab_reg] <= 1'b0;
        end
        if (tx_load && !buffer_disable && !tx_empty_reg[tx_sel]) begin
          tx_active_reg <= tx_sel;
          tx_last_reg   <= (tx_idx_reg == afe_port_pkg::BUF_LAST);
          tx_last_buf_reg <= tx_sel;
          tx_idx_reg    <= (tx_idx_reg == afe_port_pkg::BUF_LAST) ? 6'h00 : tx_idx_reg + 6'h01;
        end
        if (word_done && tx_last_reg) begin
          tx_empty_reg[tx_last_buf_reg] <= 1'b1;
          tx_active_reg <= ~tx_last_buf_reg;
          tx_last_reg   <= 1'b0;
        end
      end
    end
  end
  // Receive buffer fill, register capture and full tracking
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_word_reg <= afe_port_pkg::WORD_RESET;
      rx_full_reg <= 2'h0;
      rx_fill_reg <= 1'b0;
      rx_idx_reg  <= 6'h00;
    end else begin
      if (clr_op[afe_port_pkg::STS_RX_FULL]) begin
        rx_full_reg[rab_reg] <= 1'b0;
      end
      if (word_done && re && buffer_disable) begin
        rx_word_reg <= {rx_shifter_reg[14:0], rx_bit};
      end else if (word_done && re && !rx_full_reg[rx_fill_reg]) begin
        rx_idx_reg <= (rx_idx_reg == afe_port_pkg::BUF_LAST) ? 6'h00 : rx_idx_reg + 6'h01;
        if (rx_idx_reg == afe_port_pkg::BUF_LAST) begin
          rx_full_reg[rx_fill_reg] <= 1'b1;
          rx_fill_reg <= ~rx_fill_reg;
        end
      end
    end
  end
  // Hardware side of receive buffer
  always_ff @(posedge sys_clk) begin
    if (word_done && re && !buffer_disable && !rx_full_reg[rx_fill_reg]) begin
      rx_mem[mem_index(rx_fill_reg, rx_idx_reg)] <= {rx_shifter_reg[14:0], rx_bit};
    end
  end
  // Event pulses feeding the flags
  logic tx_err_ev, rx_err_ev, tde_ev, rdf_ev, rx_full0_ev;
  assign tx_err_ev = tx_load && (buffer_disable ? ~tx_word_full_reg : (tx_empty_reg == 2'h3));
  assign rx_err_ev = word_done && re && (buffer_disable ? rdf_reg : rx_full_reg[rx_fill_reg]);
  assign tde_ev = (word_done && tx_last_reg) || (tx_load && buffer_disable) || te_fall;
  assign rdf_ev = word_done && re &&
                  (buffer_disable || (!rx_full_reg[rx_fill_reg] && rx_idx_reg == afe_port_pkg::BUF_LAST));
  assign rx_full0_ev = rdf_ev && !buffer_disable && !rx_fill_reg;
  // Status flags; a hardware set beats a same-cycle software clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_err_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      tde_reg    <= 1'b1;
      rdf_reg    <= 1'b0;
    end else begin
      if (tx_err_ev && !te_fall) begin
        tx_err_reg <= 1'b1;
      end else if (te_fall || clr_op[afe_port_pkg::STS_TX_ERROR]) begin
        tx_err_reg <= 1'b0;
      end
      if (rx_err_ev && !re_fall) begin
        rx_err_reg <= 1'b1;
      end else if (re_fall || clr_op[afe_port_pkg::STS_RX_ERROR]) begin
        rx_err_reg <= 1'b0;
      end
      if (tde_ev) begin
        tde_reg <= 1'b1;
      end else if (clr_op[afe_port_pkg::STS_TX_EMPTY]) begin
        tde_reg <= ~buffer_disable & tx_empty_reg[~tab_reg];
      end
      if (rdf_ev) begin
        rdf_reg <= 1'b1;
      end else if (clr_op[afe_port_pkg::STS_RX_FULL]) begin
        rdf_reg <= ~buffer_disable & rx_full_reg[~rab_reg];
      end
    end
  end
  // Accessible-buffer selectors; an empty-clear beats the plain bit write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tab_reg <= 1'b0;
      rab_reg <= 1'b0;
    end else begin
      if (te_fall) begin
        tab_reg <= 1'b0;
      end else if (clr_op[afe_port_pkg::STS_TX_EMPTY]) begin
        tab_reg <= ~tab_reg;
      end else if (st_wr && !te) begin
        tab_reg <= sw_status[afe_port_pkg::STS_TX_ACCESS];
      end else if (word_done && tx_last_reg && !tx_last_buf_reg) begin
        tab_reg <= 1'b0;
      end else if (te && tx_empty_reg == 2'h2) begin
        tab_reg <= 1'b1;
      end
      if (st_wr && !re) begin
        rab_reg <= sw_status[afe_port_pkg::STS_RX_ACCESS];
      end else if (rx_full0_ev) begin
        rab_reg <= 1'b0;
      end else if (clr_op[afe_port_pkg::STS_RX_FULL]) begin
        rab_reg <= rx_full_reg[~rab_reg] ? ~rab_reg : rab_reg;
      end else if (rx_full_reg == 2'h2) begin
        rab_reg <= 1'b1;
      end
    end
  end
  // Pin and interrupt outputs, registered
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      relay_output         <= 1'b0;
      ext_chip_reset_n     <= 1'b0;
      ext_chip_powerdown_n <= 1'b0;
      ring_irq             <= 1'b0;
      tx_error_irq         <= 1'b0;
      rx_error_irq         <= 1'b0;
      tx_empty_irq         <= 1'b0;
      rx_full_irq          <= 1'b0;
    end else begin
      relay_output <= ctl_reg[afe_port_pkg::CTL_RELAY_SRC] ?
                      tx_data : ctl_reg[afe_port_pkg::CTL_RELAY_LEVEL];
      ext_chip_reset_n     <= ctl_reg[afe_port_pkg::CTL_CHIP_RESET];
      ext_chip_powerdown_n <= ctl_reg[afe_port_pkg::CTL_POWERDOWN];
      ring_irq     <= ~ring_s & ~ctl_reg[afe_port_pkg::CTL_RING_MASK];
      tx_error_irq <= tx_err_reg & ctl_reg[afe_port_pkg::CTL_TXERR_IE];
      rx_error_irq <= rx_err_reg & ctl_reg[afe_port_pkg::CTL_RXERR_IE];
      tx_empty_irq <= tde_reg & ctl_reg[afe_port_pkg::CTL_TXEMPTY_IE];
      rx_full_irq  <= rdf_reg & ctl_reg[afe_port_pkg::CTL_RXFULL_IE];
    end
  end
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
endmodule

// ---- afe_port_asserts.sv ----
// Port-level checker for the modem front-end serial port
module afe_port_asserts (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Register bus
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and request levels
  input wire logic        tx_data,
  input wire logic        relay_output,
  input wire logic        ext_chip_reset_n,
  input wire logic        ext_chip_powerdown_n,
  input wire logic        ring_irq,
  input wire logic        tx_error_irq,
  input wire logic        rx_error_irq,
  input wire logic        tx_empty_irq,
  input wire logic        rx_full_irq
);
  logic [15:0] ctl_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Shadow of control; pins are only judged once it has stood one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctl_reg <= 16'h0000;
    end else if (avs_write && !avs_waitrequest && avs_address == afe_port_pkg::IDX_CONTROL) begin
      if (avs_byteenable[0]) ctl_reg[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) ctl_reg[15:8] <= avs_writedata[15:8];
    end
  end
  a_wait_answer: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_status_rsvd: assert property (avs_read && !avs_waitrequest &&
    avs_address == afe_port_pkg::IDX_STATUS |-> avs_readdata[13:4] == 10'h000)
    else $error("reserved status bits set");
  a_reset_pin: assert property (ctl_reg == $past(ctl_reg) |-> ext_chip_reset_n == ctl_reg[10])
    else $error("chip reset pin differs from control");
  a_pwrdn_pin: assert property (ctl_reg == $past(ctl_reg) |->
    ext_chip_powerdown_n == ctl_reg[11])
    else $error("power-down pin differs from control");
  a_relay_pin: assert property (ctl_reg == $past(ctl_reg) |->
    relay_output == (ctl_reg[9] ? $past(tx_data) : ctl_reg[12]))
    else $error("relay pin wrong source");
  a_tx_idle: assert property (ctl_reg == $past(ctl_reg) && !ctl_reg[1] |-> !tx_data)
    else $error("serial data moves while transmit off");
  a_irq_gated: assert property (ctl_reg == $past(ctl_reg) |-> !(ring_irq && ctl_reg[7]) &&
    ({tx_error_irq, rx_error_irq, tx_empty_irq, rx_full_irq} & ~ctl_reg[6:3]) == 4'h0)
    else $error("request raised while disabled");
endmodule

bind modem_afe_serial_port afe_port_asserts u_afe_port_asserts (.sys_clk, .srst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .tx_data, .relay_output, .ext_chip_reset_n, .ext_chip_powerdown_n, .ring_irq, .tx_error_irq,
  .rx_error_irq, .tx_empty_irq, .rx_full_irq);

// ---- afe_frontend_model.sv ----
// Behavioural modem front end: frames the link, sends and captures words
module afe_frontend_model (
  // Link pins
  output logic      shift_clk,
  output logic      frame_sync,
  output logic      rx_data,
  input  wire logic tx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Link clock stands low outside frames
  initial begin
    shift_clk = 1'b0;
    frame_sync = 1'b0;
    rx_data = 1'b1;
  end
  // One frame of 16 shift clocks; pins move by NBA so no sampling flop races them
  task automatic frame(input logic [15:0] rw, output logic [15:0] tw);
    frame_sync <= 1'b1;
    #400;
    for (int i = 15; i >= 0; i--) begin
      rx_data <= rw[i];
      shift_clk <= 1'b1;
      #400;
      tw[i] = tx_data;
      frame_sync <= 1'b0;
      shift_clk <= 1'b0;
      #400;
    end
    rx_data <= ~rx_data; // Released line must not keep the last bit
  endtask
endmodule

// ---- modem_afe_serial_port_tb.sv ----
// Self-checking bench for the modem front-end serial port
module modem_afe_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] CT = afe_port_pkg::IDX_CONTROL;
  localparam logic [9:0] ST = afe_port_pkg::IDX_STATUS;
  logic        sys_clk, srst, avs_read, avs_write, avs_waitrequest, ring_in, shift_clk;
  logic        frame_sync, rx_data, tx_data, relay_output, ext_chip_reset_n, ext_chip_powerdown_n;
  logic        ring_irq, tx_error_irq, rx_error_irq, tx_empty_irq, rx_full_irq;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [3:0]  avs_byteenable;
  logic [15:0] q, w, r, t, txq[$], rxq[$];
  int          fails, n_tests;
  modem_afe_serial_port u_modem_afe_serial_port (.sys_clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .shift_clk,
    .frame_sync, .rx_data, .ring_in, .tx_data, .relay_output, .ext_chip_reset_n,
    .ext_chip_powerdown_n, .ring_irq, .tx_error_irq, .rx_error_irq, .tx_empty_irq, .rx_full_irq);
  afe_frontend_model u_afe_frontend_model (.shift_clk, .frame_sync, .rx_data, .tx_data);
  // Compare one result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      fails++;
      $display("[ERR] %0t bus hang", $time);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e, input logic [15:0] m);
    bus(1'b0, a, 16'h0000);
    chk(q & m, e);
  endtask
  task automatic end_sim;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the 51 frames of traffic
  initial begin
    #3000000;
    fails++;
    $display("[ERR] %0t watchdog", $time);
    end_sim();
  end
  initial begin
    {srst, avs_read, avs_write, ring_in} = 4'h9;
    {avs_address, avs_writedata, avs_byteenable} = {10'h000, 32'h0, 4'h3};
    {fails, n_tests, seed} = {32'd0, 32'd0, 32'h75A3CFC5};
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rd(ST, 16'h0002, 16'hFFFF);
    rd(CT, 16'h0000, 16'hFFFF);
    rd(afe_port_pkg::IDX_RX_WORD, 16'h0000, 16'hFFFF);
    rd(afe_port_pkg::IDX_TX_WORD, 16'h0000, 16'hFFFF);
    rd(10'h3FF, 16'h0000, 16'hFFFF);
    // Every combination of the three level pins
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, CT, 16'(k) << 10);
      repeat (2) @(posedge sys_clk);
      chk({13'h0, relay_output, ext_chip_powerdown_n, ext_chip_reset_n}, 16'(k));
    end
    bus(1'b1, ST, 16'h400F);
    rd(ST, 16'h4002, 16'hFFFF);
    bus(1'b1, ST, 16'h000F);
    // Single-word mode with the four flag requests enabled and the ring request left unmasked
    bus(1'b1, CT, 16'h027F);
    w = $random(seed);
    r = $random(seed);
    bus(1'b1, afe_port_pkg::IDX_TX_WORD, w);
    u_afe_frontend_model.frame(r, t);
    chk(t, w);
    repeat (8) @(posedge sys_clk);
    rd(afe_port_pkg::IDX_RX_WORD, r, 16'hFFFF);
    rd(ST, 16'h0003, 16'h3FFF);
    chk({14'h0, tx_empty_irq, rx_full_irq}, 16'h0003);
    bus(1'b1, ST, 16'h3FFE);
    bus(1'b1, ST, 16'h3FFD);
    rd(ST, 16'h0002, 16'h3FFF);
    bus(1'b1, ST, 16'h3FFD);
    rd(ST, 16'h0000, 16'h3FFF);
    // Two frames with no new word: transmit error, then receive error; second from ring pin
    for (int k = 0; k < 2; k++) begin
      if (k == 1) bus(1'b1, CT, 16'h017F);
      u_afe_frontend_model.frame(16'($random(seed)), t);
      repeat (8) @(posedge sys_clk);
      rd(ST, k ? 16'h000D : 16'h0009, 16'h3FFD);
    end
    chk({14'h0, tx_error_irq, rx_error_irq}, 16'h0003);
    rd(afe_port_pkg::IDX_RX_WORD, 16'hFFFF, 16'hFFFF);
    ring_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({15'h0, ring_irq}, 16'h0001);
    bus(1'b1, CT, 16'h01FF);
    repeat (3) @(posedge sys_clk);
    chk({15'h0, ring_irq}, 16'h0000);
    ring_in <= 1'b1;
    bus(1'b1, CT, 16'h0004);
    rd(ST, 16'h0003, 16'hBFFF);
    // Buffer mode: fill both transmit buffers with the two-step clear
    bus(1'b1, CT, 16'h0000);
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 48; k++) begin
        w = $random(seed);
        txq.push_back(w);
        bus(1'b1, afe_port_pkg::IDX_TX_BUF + 10'(2 * k), w);
      end
      bus(1'b0, ST, 16'h0000);
      bus(1'b1, ST, q & 16'hFFFC);
      rd(ST, b ? 16'h0000 : 16'h8002, 16'hBFFF);
    end
    bus(1'b1, CT, 16'h0003);
    for (int k = 0; k < 48; k++) begin
      r = $random(seed);
      rxq.push_back(r);
      u_afe_frontend_model.frame(r, t);
      chk(t, txq.pop_front());
    end
    repeat (8) @(posedge sys_clk);
    rd(ST, 16'h0003, 16'hFFFF);
    for (int k = 0; k < 48; k++) begin
      rd(afe_port_pkg::IDX_RX_BUF + 10'(2 * k), rxq.pop_front(), 16'hFFFF);
    end
    // Full-clear releases the one full buffer that the access bit names
    bus(1'b0, ST, 16'h0000);
    bus(1'b1, ST, q & 16'hFFFE);
    rd(ST, 16'h0002, 16'hFFFF);
    end_sim();
  end
endmodule
